// ==== hw/gpmx_pkg.sv ====
// Package for the general-purpose port block with pin function multiplexing.
// Assumes registers are reached as 32-bit APB words at byte address four times the index.
package gpmx_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_PORT0_INPUT_DATA      = 16'h5200;
  localparam logic [15:0] IDX_PORT0_OUTPUT_DATA     = 16'h5201;
  localparam logic [15:0] IDX_PORT0_DIRECTION       = 16'h5202;
  localparam logic [15:0] IDX_PORT0_PULLUP          = 16'h5203;
  localparam logic [15:0] IDX_PORT1_INPUT_DATA      = 16'h5210;
  localparam logic [15:0] IDX_PORT1_OUTPUT_DATA     = 16'h5211;
  localparam logic [15:0] IDX_PORT1_DIRECTION       = 16'h5212;
  localparam logic [15:0] IDX_PORT1_PULLUP          = 16'h5213;
  localparam logic [15:0] IDX_PORT2_INPUT_DATA      = 16'h5220;
  localparam logic [15:0] IDX_PORT2_OUTPUT_DATA     = 16'h5221;
  localparam logic [15:0] IDX_PORT2_DIRECTION       = 16'h5222;
  localparam logic [15:0] IDX_PORT2_PULLUP          = 16'h5223;
  localparam logic [15:0] IDX_PORT3_INPUT_DATA      = 16'h5230;
  localparam logic [15:0] IDX_PORT3_OUTPUT_DATA     = 16'h5231;
  localparam logic [15:0] IDX_PORT3_DIRECTION       = 16'h5232;
  localparam logic [15:0] IDX_PORT3_PULLUP          = 16'h5233;
  localparam logic [15:0] IDX_PORT0_FUNCTION_SELECT = 16'h52A0;
  localparam logic [15:0] IDX_PORT1_FUNCTION_SELECT = 16'h52A1;
  localparam logic [15:0] IDX_PORT2_FUNCTION_SELECT = 16'h52A2;
  localparam logic [15:0] IDX_PORT3_FUNCTION_SELECT = 16'h52A3;

  // ---------------------------------------------------------------
  // Register kinds and field layout per group
  // ---------------------------------------------------------------
  localparam logic [2:0] KIND_IN   = 3'h0;
  localparam logic [2:0] KIND_OUT  = 3'h1;
  localparam logic [2:0] KIND_DIR  = 3'h2;
  localparam logic [2:0] KIND_PU   = 3'h3;
  localparam logic [2:0] KIND_FSEL = 3'h4;
  localparam logic [7:0] GRP_MASK  [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F};
  localparam logic [7:0] FSEL_MASK [4] = '{8'h30, 8'h38, 8'hFF, 8'h0F};
  localparam logic [7:0] FSEL_INV  [4] = '{8'h00, 8'h00, 8'h00, 8'h0E};

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  OUT_RST  = 8'h00;
  localparam logic [7:0]  DIR_RST  = 8'h00;
  localparam logic [7:0]  PU_RST   = 8'hFF;
  localparam logic [7:0]  FSEL_RST = 8'h00;
  localparam logic [27:0] PINS_ON  = 28'hFFFFFFF;

  // ---------------------------------------------------------------
  // Flat pin positions of shared functions
  // ---------------------------------------------------------------
  localparam int PIN_REMOTE_CONTROL_INPUT      = 4;
  localparam int PIN_REMOTE_CONTROL_OUTPUT     = 5;
  localparam int PIN_TIMER16_CLOCK_2           = 6;
  localparam int PIN_TIMER16_CLOCK_1           = 7;
  localparam int PIN_SUB_OSCILLATOR_CLOCK_OUT  = 11;
  localparam int PIN_TIMER16_CLOCK_0           = 14;
  localparam int PIN_UART_RECEIVE_LINE         = 19;
  localparam int PIN_PWM_TIMER_OUTPUT          = 22;
  localparam int PIN_MAIN_OSCILLATOR_CLOCK_OUT = 24;
  localparam int PIN_DEBUG_CLOCK_LINE          = 25;

endpackage : gpmx_pkg

// ==== hw/gpmx_port.sv ====
// Port logic for 28 shared pins: direction, output data, pull-up and function select.
// Assumes an APB master on clk_in and peripherals that drive their own pin direction.
//
// Design decision made here: register access over APB.

`timescale 1ns/100ps
`default_nettype none

module gpmx_port (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [17:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Pins
  input  wire logic [27:0] pad_in,
  output logic      [27:0] pad_out,
  output logic      [27:0] pad_oe_n_out,
  output logic      [27:0] pullup_en_out,
  // Peripheral side
  input  wire logic [27:0] periph_level_in,
  input  wire logic [27:0] periph_dir_in,
  output logic      [27:0] periph_level_out,
  output logic      [2:0]  timer16_clock_out,
  output logic      [15:0] pin_change_out
);

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  // Result is {hit, kind, group}.
  function automatic logic [5:0] gpmx_decode(input logic [17:0] addr);
    logic [15:0] idx;
    logic [5:0]  res;
    idx = addr[17:2];
    res = 6'h00;
    case (idx)
      gpmx_pkg::IDX_PORT0_INPUT_DATA:      res = {1'h1, gpmx_pkg::KIND_IN, 2'h0};
      gpmx_pkg::IDX_PORT0_OUTPUT_DATA:     res = {1'h1, gpmx_pkg::KIND_OUT, 2'h0};
      gpmx_pkg::IDX_PORT0_DIRECTION:       res = {1'h1, gpmx_pkg::KIND_DIR, 2'h0};
      gpmx_pkg::IDX_PORT0_PULLUP:          res = {1'h1, gpmx_pkg::KIND_PU, 2'h0};
      gpmx_pkg::IDX_PORT1_INPUT_DATA:      res = {1'h1, gpmx_pkg::KIND_IN, 2'h1};
      gpmx_pkg::IDX_PORT1_OUTPUT_DATA:     res = {1'h1, gpmx_pkg::KIND_OUT, 2'h1};
      gpmx_pkg::IDX_PORT1_DIRECTION:       res = {1'h1, gpmx_pkg::KIND_DIR, 2'h1};
      gpmx_pkg::IDX_PORT1_PULLUP:          res = {1'h1, gpmx_pkg::KIND_PU, 2'h1};
      gpmx_pkg::IDX_PORT2_INPUT_DATA:      res = {1'h1, gpmx_pkg::KIND_IN, 2'h2};
      gpmx_pkg::IDX_PORT2_OUTPUT_DATA:     res = {1'h1, gpmx_pkg::KIND_OUT, 2'h2};
      gpmx_pkg::IDX_PORT2_DIRECTION:       res = {1'h1, gpmx_pkg::KIND_DIR, 2'h2};
      gpmx_pkg::IDX_PORT2_PULLUP:          res = {1'h1, gpmx_pkg::KIND_PU, 2'h2};
      gpmx_pkg::IDX_PORT3_INPUT_DATA:      res = {1'h1, gpmx_pkg::KIND_IN, 2'h3};
      gpmx_pkg::IDX_PORT3_OUTPUT_DATA:     res = {1'h1, gpmx_pkg::KIND_OUT, 2'h3};
      gpmx_pkg::IDX_PORT3_DIRECTION:       res = {1'h1, gpmx_pkg::KIND_DIR, 2'h3};
      gpmx_pkg::IDX_PORT3_PULLUP:          res = {1'h1, gpmx_pkg::KIND_PU, 2'h3};
      gpmx_pkg::IDX_PORT0_FUNCTION_SELECT: res = {1'h1, gpmx_pkg::KIND_FSEL, 2'h0};
      gpmx_pkg::IDX_PORT1_FUNCTION_SELECT: res = {1'h1, gpmx_pkg::KIND_FSEL, 2'h1};
      gpmx_pkg::IDX_PORT2_FUNCTION_SELECT: res = {1'h1, gpmx_pkg::KIND_FSEL, 2'h2};
      gpmx_pkg::IDX_PORT3_FUNCTION_SELECT: res = {1'h1, gpmx_pkg::KIND_FSEL, 2'h3};
      default:                             res = 6'h00;
    endcase
    return res;
  endfunction : gpmx_decode

  // ---------------------------------------------------------------
  // Bus state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } gpmx_bus_state_t;

  gpmx_bus_state_t state_ff;
  logic [31:0]     prdata_ff;
  logic            pslverr_ff;
  logic [5:0]      dec;
  logic            wr_done;
  logic [7:0]      rd_byte;

  logic [7:0]  out_ff  [4];
  logic [7:0]  dir_ff  [4];
  logic [7:0]  pu_ff   [4];
  logic [7:0]  fsel_ff [4];
  logic [27:0] pin_meta_ff;
  logic [27:0] pin_sync_ff;
  logic [15:0] pin_prev_ff;
  logic [27:0] pad_out_ff;
  logic [27:0] pad_oe_n_ff;
  logic [27:0] pullup_ff;
  logic [27:0] periph_lvl_ff;
  logic [2:0]  tmr_clk_ff;
  logic [15:0] change_ff;

  logic [27:0] out_flat;
  logic [27:0] dir_flat;
  logic [27:0] pu_flat;
  logic [27:0] fsel_flat;
  logic [27:0] inv_flat;
  logic [27:0] periph_sel;
  logic [27:0] nxt_drive;
  logic [27:0] nxt_level;

  assign dec     = gpmx_decode(paddr_in);
  // The write lands on the edge where the master sees pready high.
  assign wr_done = (state_ff == ST_ACK) && psel_in && penable_in && pwrite_in && dec[5];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff   <= ST_IDLE;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (psel_in && penable_in) begin
            state_ff   <= ST_ACK;
            prdata_ff  <= (pwrite_in || !dec[5]) ? 32'h00000000 : {24'h000000, rd_byte};
            pslverr_ff <= !dec[5];
          end
        end
        ST_ACK: begin
          state_ff   <= ST_IDLE;
          pslverr_ff <= 1'h0;
        end
        default: begin
          state_ff   <= ST_IDLE;
          pslverr_ff <= 1'h0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0]  g;
    logic [31:0] pins_word;
    g         = dec[1:0];
    // Group 3 has only four pins, so the top nibble of the word is padding.
    pins_word = {4'h0, pin_sync_ff};
    rd_byte   = 8'h00;
    case (dec[4:2])
      gpmx_pkg::KIND_IN: begin
        rd_byte = pins_word[8*g +: 8] & gpmx_pkg::GRP_MASK[g];
      end
      gpmx_pkg::KIND_OUT:  rd_byte = out_ff[g];
      gpmx_pkg::KIND_DIR:  rd_byte = dir_ff[g];
      gpmx_pkg::KIND_PU:   rd_byte = pu_ff[g];
      gpmx_pkg::KIND_FSEL: rd_byte = fsel_ff[g];
      default:             rd_byte = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Control registers, one set per group
  // ---------------------------------------------------------------
  // Masks on write keep unused bits at zero, so reads need no masking.
  for (genvar g = 0; g < 4; g++) begin : g_grp
    logic hit;
    assign hit = wr_done && (dec[1:0] == 2'(g));
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        out_ff[g]  <= gpmx_pkg::OUT_RST;
        dir_ff[g]  <= gpmx_pkg::DIR_RST;
        pu_ff[g]   <= gpmx_pkg::PU_RST & gpmx_pkg::GRP_MASK[g];
        fsel_ff[g] <= gpmx_pkg::FSEL_RST;
      end else if (hit) begin
        case (dec[4:2])
          gpmx_pkg::KIND_OUT: begin
            out_ff[g] <= pwdata_in[7:0] & gpmx_pkg::GRP_MASK[g];
          end
          gpmx_pkg::KIND_DIR: begin
            dir_ff[g] <= pwdata_in[7:0] & gpmx_pkg::GRP_MASK[g];
          end
          gpmx_pkg::KIND_PU: begin
            pu_ff[g] <= pwdata_in[7:0] & gpmx_pkg::GRP_MASK[g];
          end
          gpmx_pkg::KIND_FSEL: begin
            fsel_ff[g] <= pwdata_in[7:0] & gpmx_pkg::FSEL_MASK[g];
          end
          default: begin
            out_ff[g] <= out_ff[g];
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin multiplexing
  // ---------------------------------------------------------------
  assign out_flat  = {out_ff[3][3:0], out_ff[2], out_ff[1], out_ff[0]};
  assign dir_flat  = {dir_ff[3][3:0], dir_ff[2], dir_ff[1], dir_ff[0]};
  assign pu_flat   = {pu_ff[3][3:0], pu_ff[2], pu_ff[1], pu_ff[0]};
  assign fsel_flat = {fsel_ff[3][3:0], fsel_ff[2], fsel_ff[1], fsel_ff[0]};
  assign inv_flat  = {gpmx_pkg::FSEL_INV[3][3:0], gpmx_pkg::FSEL_INV[2],
                      gpmx_pkg::FSEL_INV[1], gpmx_pkg::FSEL_INV[0]};

  // Debug pins of group 3 belong to the debugger while their bit is 0.
  assign periph_sel = fsel_flat ^ inv_flat;
  assign nxt_drive  = (periph_sel & periph_dir_in) | (~periph_sel & dir_flat);
  assign nxt_level  = (periph_sel & periph_level_in) | (~periph_sel & out_flat);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pad_out_ff  <= 28'h0000000;
      pad_oe_n_ff <= gpmx_pkg::PINS_ON;
      pullup_ff   <= gpmx_pkg::PINS_ON;
    end else begin
      pad_out_ff  <= nxt_level;
      pad_oe_n_ff <= ~nxt_drive;
      pullup_ff   <= pu_flat & ~nxt_drive;
    end
  end

  // ---------------------------------------------------------------
  // Pin inputs
  // ---------------------------------------------------------------
  // Synchronisers start at the pulled-up idle level, so release of reset shows no false change.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_meta_ff <= gpmx_pkg::PINS_ON;
      pin_sync_ff <= gpmx_pkg::PINS_ON;
    end else begin
      pin_meta_ff <= pad_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Peripherals see the pin only while they own it.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      periph_lvl_ff <= 28'h0000000;
    end else begin
      periph_lvl_ff <= pin_sync_ff & periph_sel;
    end
  end

  // These three pins have no select bit; GPIO stays usable beside the timer.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tmr_clk_ff <= 3'h0;
    end else begin
      tmr_clk_ff[0] <= pin_sync_ff[gpmx_pkg::PIN_TIMER16_CLOCK_0]
                       & ~dir_flat[gpmx_pkg::PIN_TIMER16_CLOCK_0];
      tmr_clk_ff[1] <= pin_sync_ff[gpmx_pkg::PIN_TIMER16_CLOCK_1]
                       & ~dir_flat[gpmx_pkg::PIN_TIMER16_CLOCK_1];
      tmr_clk_ff[2] <= pin_sync_ff[gpmx_pkg::PIN_TIMER16_CLOCK_2]
                       & ~dir_flat[gpmx_pkg::PIN_TIMER16_CLOCK_2];
    end
  end

  // Only groups 0 and 1 report level changes; edge choice lives downstream.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_prev_ff <= gpmx_pkg::PINS_ON[15:0];
      change_ff   <= 16'h0000;
    end else begin
      pin_prev_ff <= pin_sync_ff[15:0];
      change_ff   <= pin_sync_ff[15:0] ^ pin_prev_ff;
    end
  end

  assign prdata_out        = prdata_ff;
  assign pready_out        = state_ff[1];
  assign pslverr_out       = pslverr_ff;
  assign pad_out           = pad_out_ff;
  assign pad_oe_n_out      = pad_oe_n_ff;
  assign pullup_en_out     = pullup_ff;
  assign periph_level_out  = periph_lvl_ff;
  assign timer16_clock_out = tmr_clk_ff;
  assign pin_change_out    = change_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_setup_in0;
    psel_in && !penable_in && !pwrite_in
      && paddr_in[17:2] == gpmx_pkg::IDX_PORT0_INPUT_DATA && state_ff == ST_IDLE;
  endsequence
  sequence s_access_wait;
    psel_in && penable_in && !pready_out;
  endsequence

  property p_rd_input;
    logic [7:0] lvl;
    (s_setup_in0 ##1 (s_access_wait, lvl = pin_sync_ff[7:0]))
      |=> pready_out && prdata_out[7:0] == lvl;
  endproperty
  a_rd_input: assert property (p_rd_input)
    else $error("input data read does not return pin levels");

  property p_in_mode_hiz;
    !dir_flat[0] |=> pad_oe_n_out[0] ##1 pad_oe_n_out[0] || dir_flat[0] != 1'h0;
  endproperty
  a_in_mode_hiz: assert property (p_in_mode_hiz)
    else $error("input pin driver not released");

  property p_out_level;
    dir_flat[1] |=> !pad_oe_n_out[1] && pad_out[1] == $past(out_flat[1]);
  endproperty
  a_out_level: assert property (p_out_level)
    else $error("output pin does not drive its data bit");

  property p_pullup_off;
    !(|(~pad_oe_n_out & pullup_en_out));
  endproperty
  a_pullup_off: assert property (p_pullup_off)
    else $error("pull-up on while pin drives");

  property p_pullup_on;
    (!dir_flat[2] && pu_flat[2]) |=> pullup_en_out[2] && pad_oe_n_out[2];
  endproperty
  a_pullup_on: assert property (p_pullup_on)
    else $error("enabled pull-up missing on input pin");

  property p_periph_dir;
    (fsel_flat[16] && periph_dir_in[16] && !dir_flat[16]) |=> !pad_oe_n_out[16];
  endproperty
  a_periph_dir: assert property (p_periph_dir)
    else $error("peripheral direction not applied");

  property p_dbg_default;
    (!fsel_flat[gpmx_pkg::PIN_DEBUG_CLOCK_LINE] && dir_flat[gpmx_pkg::PIN_DEBUG_CLOCK_LINE]
      && !periph_dir_in[gpmx_pkg::PIN_DEBUG_CLOCK_LINE])
      |=> pad_oe_n_out[gpmx_pkg::PIN_DEBUG_CLOCK_LINE];
  endproperty
  a_dbg_default: assert property (p_dbg_default)
    else $error("debug pin not owned by debugger at select 0");

  property p_timer_clk;
    (pin_sync_ff[gpmx_pkg::PIN_TIMER16_CLOCK_2] && !dir_flat[gpmx_pkg::PIN_TIMER16_CLOCK_2])
      |=> timer16_clock_out[2];
  endproperty
  a_timer_clk: assert property (p_timer_clk)
    else $error("timer clock input not fed from pin");

  property p_fsel_mask;
    (wr_done && dec[4:2] == gpmx_pkg::KIND_FSEL && dec[1:0] == 2'h0)
      |=> fsel_ff[0] == ($past(pwdata_in[7:0]) & 8'h30);
  endproperty
  a_fsel_mask: assert property (p_fsel_mask)
    else $error("unused select bits stored");

  property p_rst_fsel;
    $fell(rst_in) |-> fsel_flat == 28'h0000000 && dir_flat == 28'h0000000;
  endproperty
  a_rst_fsel: assert property (@(posedge clk_in) p_rst_fsel)
    else $error("select or direction not cleared by reset");

  property p_change;
    $changed(pin_sync_ff[8]) |=> pin_change_out[8];
  endproperty
  a_change: assert property (p_change)
    else $error("pin change not reported");

endmodule : gpmx_port

`default_nettype wire

// ==== dv/gpmx_board.sv ====
// Board model for the port pins: settles each pin from the device driver, the
// pull-up and an external source that the bench controls.
// Assumes the device drives a pin only while its active-low enable is 0.
`timescale 1ns/100ps
`default_nettype none

module gpmx_board (
  // Clock
  input  wire logic        clk_in,
  // Device side
  input  wire logic [27:0] pad_out_in,
  input  wire logic [27:0] pad_oe_n_in,
  input  wire logic [27:0] pullup_en_in,
  // Bench side
  input  wire logic [27:0] ext_drive_in,
  input  wire logic [27:0] ext_level_in,
  output logic      [27:0] pad_level_out
);
  // A floating pin toggles every cycle so that no settled level can pass by luck.
  logic [27:0] float_ff = 28'h0000000;

  always @(posedge clk_in) begin
    float_ff <= ~float_ff;
  end

  always_comb begin
    for (int i = 0; i < 28; i++) begin
      if (!pad_oe_n_in[i])
        pad_level_out[i] = pad_out_in[i];
      else if (ext_drive_in[i])
        pad_level_out[i] = ext_level_in[i];
      else if (pullup_en_in[i])
        pad_level_out[i] = 1'b1;
      else
        pad_level_out[i] = float_ff[i];
    end
  end
endmodule : gpmx_board

`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the port block: APB registers, pin levels and muxing.
// Assumes the board model settles every pin; all stimulus changes at rising edges.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module testbench;
  typedef struct packed {logic [15:0] idx; logic [7:0] wd; logic [7:0] rd; logic err;} gpmx_row_t;
  logic        clk_in   = 1'b0;
  logic        rst_in   = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [17:0] paddr    = 18'h00000;
  logic [31:0] pwdata   = 32'h00000000;
  logic [27:0] per_lvl  = 28'h0000000;
  logic [27:0] per_dir  = 28'h0000000;
  logic [27:0] ext_drv  = 28'h0000000;
  logic [27:0] ext_lvl  = 28'h0000000;
  logic [31:0] prdata, rd;
  logic [27:0] pad_lvl, pad_out, pad_oe_n, pullup_en, per_out;
  logic [15:0] pin_chg;
  logic [2:0]  t16_clk;
  logic        pready, pslverr, er;
  int          n_errors = 0;
  int          checked  = 0;
  int          pulses, others;
  gpmx_row_t   rows [8] = '{
    '{gpmx_pkg::IDX_PORT0_OUTPUT_DATA,     8'hA5, 8'hA5, 1'b0},
    '{gpmx_pkg::IDX_PORT3_DIRECTION,       8'hFF, 8'h0F, 1'b0},
    '{gpmx_pkg::IDX_PORT3_PULLUP,          8'hF3, 8'h03, 1'b0},
    '{gpmx_pkg::IDX_PORT0_FUNCTION_SELECT, 8'hFF, 8'h30, 1'b0},
    '{gpmx_pkg::IDX_PORT1_FUNCTION_SELECT, 8'hFF, 8'h38, 1'b0},
    '{gpmx_pkg::IDX_PORT2_FUNCTION_SELECT, 8'h5A, 8'h5A, 1'b0},
    '{gpmx_pkg::IDX_PORT3_FUNCTION_SELECT, 8'hFF, 8'h0F, 1'b0},
    '{16'h5240,                            8'hFF, 8'h00, 1'b1}};
  logic [15:0] ridx [6] = '{gpmx_pkg::IDX_PORT0_FUNCTION_SELECT,
    gpmx_pkg::IDX_PORT3_FUNCTION_SELECT, gpmx_pkg::IDX_PORT2_FUNCTION_SELECT,
    gpmx_pkg::IDX_PORT0_DIRECTION, gpmx_pkg::IDX_PORT0_PULLUP, gpmx_pkg::IDX_PORT3_PULLUP};
  logic [7:0]  rexp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h0F};

  // The clock runs from time zero, before any register access.
  initial begin
    forever #4 clk_in = ~clk_in;
  end

  gpmx_port u_gpmx_port (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pad_in(pad_lvl), .pad_out(pad_out),
    .pad_oe_n_out(pad_oe_n), .pullup_en_out(pullup_en), .periph_level_in(per_lvl),
    .periph_dir_in(per_dir), .periph_level_out(per_out), .timer16_clock_out(t16_clk),
    .pin_change_out(pin_chg));

  gpmx_board u_gpmx_board (
    .clk_in(clk_in), .pad_out_in(pad_out), .pad_oe_n_in(pad_oe_n),
    .pullup_en_in(pullup_en), .ext_drive_in(ext_drv), .ext_level_in(ext_lvl),
    .pad_level_out(pad_lvl));

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // A pin change needs three edges to reach a registered output; reads here see pre-edge values.
  task automatic settle;
    repeat (6) @(posedge clk_in);
  endtask : settle

  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd);
      `CHK(er, rows[i].err)
      apb(1'b0, rows[i].idx, 8'h00);
      `CHK(rd, {24'h000000, rows[i].rd})
      `CHK(er, rows[i].err)
    end
    // A second reset in mid-run must restore pad enables, pull-ups and the select, direction and pull-up registers read back below.
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK(pad_oe_n, 28'hFFFFFFF)
    `CHK(pullup_en, 28'hFFFFFFF)
    rst_in <= 1'b0;
    foreach (ridx[i]) begin
      apb(1'b0, ridx[i], 8'h00);
      `CHK(rd[7:0], rexp[i])
    end
    apb(1'b1, gpmx_pkg::IDX_PORT0_OUTPUT_DATA, 8'hA5);
    settle();
    `CHK(pad_oe_n[7:0], 8'hFF)
    apb(1'b1, gpmx_pkg::IDX_PORT0_DIRECTION, 8'hFF);
    settle();
    `CHK(pad_oe_n[7:0], 8'h00)
    `CHK(pad_out[7:0], 8'hA5)
    `CHK(pullup_en[7:0], 8'h00)
    apb(1'b0, gpmx_pkg::IDX_PORT0_INPUT_DATA, 8'h00);
    `CHK(rd, 32'h000000A5)
    apb(1'b0, gpmx_pkg::IDX_PORT1_INPUT_DATA, 8'h00);
    `CHK(rd, 32'h000000FF)
    apb(1'b1, gpmx_pkg::IDX_PORT1_PULLUP, 8'h00);
    ext_drv <= 28'hFFFFF00;
    ext_lvl <= 28'hFFF7C40;
    settle();
    `CHK(pullup_en[15:8], 8'h00)
    `CHK(pad_oe_n[15:8], 8'hFF)
    apb(1'b0, gpmx_pkg::IDX_PORT1_INPUT_DATA, 8'h00);
    `CHK(rd, 32'h0000007C)
    apb(1'b0, gpmx_pkg::IDX_PORT3_INPUT_DATA, 8'h00);
    `CHK(rd, 32'h0000000F)
    apb(1'b1, gpmx_pkg::IDX_PORT0_DIRECTION, 8'h3F);
    ext_drv[7:6] <= 2'b11;
    ext_lvl[7:6] <= 2'b11;
    settle();
    `CHK(t16_clk, 3'b111)
    apb(1'b1, gpmx_pkg::IDX_PORT0_DIRECTION, 8'hFF);
    settle();
    `CHK(t16_clk, 3'b001)
    ext_lvl[8]  <= 1'b1;
    ext_lvl[16] <= 1'b0;
    pulses = 0;
    others = 0;
    repeat (8) begin
      @(posedge clk_in);
      pulses += (pin_chg[8] === 1'b1);
      others += ((pin_chg & 16'hFEFF) !== 16'h0000);
    end
    `CHK(pulses, 1)
    `CHK(others, 0)
    apb(1'b1, gpmx_pkg::IDX_PORT2_FUNCTION_SELECT, 8'hFF);
    per_dir[23:16] <= 8'hFF;
    per_lvl[23:16] <= 8'hC3;
    settle();
    `CHK(pad_oe_n[23:16], 8'h00)
    `CHK(pad_out[23:16], 8'hC3)
    per_dir[23:16] <= 8'h00;
    ext_lvl[23:16] <= 8'h96;
    settle();
    `CHK(per_out[23:16], 8'h96)
    `CHK(per_out[15:0], 16'h0000)
    `CHK(per_out[27:24], 4'hE)
    apb(1'b1, gpmx_pkg::IDX_PORT3_FUNCTION_SELECT, 8'h0F);
    settle();
    `CHK(per_out[27:24], 4'h1)
    summarize();
  end
endmodule : testbench

`default_nettype wire
